// >>> rtl/sfs_spi_slave.sv
// module: serial peripheral slave front end for the user flash array
`timescale 1ns/1ns
module sfs_spi_slave #(
  parameter bit EXTENDED      = 1'b1,
  parameter bit READ_ONLY     = 1'b0,
  parameter int WRITE_CYCLES  = sfs_pkg::WRITE_CYCLES,
  parameter int SECTOR_CYCLES = sfs_pkg::SECTOR_CYCLES,
  parameter int FULL_CYCLES   = sfs_pkg::FULL_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_select_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  output logic      o_so,
  output logic      o_so_oe,
  output logic      o_oscillator_run
);
  localparam int DW  = EXTENDED ? 16 : 8;
  localparam int AW  = EXTENDED ? 9 : 8;
  localparam int CW  = 6;

  typedef enum logic [2:0] {
    SFS_IDLE, SFS_OPCODE, SFS_ADDR, SFS_DATA_IN, SFS_DATA_OUT, SFS_STAT_IN, SFS_STAT_OUT,
    SFS_WAIT
  } sfs_state_t;

  // ***************************************************************
  // synchronisers and edge detect
  // ***************************************************************
  logic sel_n_s, sck_s, si_s, sel_n_d, sck_d;
  sfs_sync #(.RESET_VAL(1'b1)) u_sync_sel (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_async(i_select_n), .o_sync(sel_n_s));
  sfs_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_async(i_sck), .o_sync(sck_s));
  sfs_sync #(.RESET_VAL(1'b0)) u_sync_si (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_async(i_si), .o_sync(si_s));

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_n_d <= 1'b1;
      sck_d   <= 1'b0;
    end else begin
      sel_n_d <= sel_n_s;
      sck_d   <= sck_s;
    end
  end

  logic sel_fall, sel_rise, active, sck_rise, sck_fall;
  assign sel_fall = sel_n_d && !sel_n_s;
  assign sel_rise = !sel_n_d && sel_n_s;
  assign active   = !sel_n_s;
  assign sck_rise = active && !sck_d && sck_s;
  assign sck_fall = active && sck_d && !sck_s;

  // ***************************************************************
  // opcode decode
  // ***************************************************************
  function automatic logic op_known(input logic [7:0] op);
    op_known = (op == sfs_pkg::OP_WRITE_ENABLE) || (op == sfs_pkg::OP_WRITE_DISABLE) ||
               (op == sfs_pkg::OP_STATUS_READ) || (op == sfs_pkg::OP_STATUS_WRITE) ||
               (op == sfs_pkg::OP_ARRAY_READ) || (op == sfs_pkg::OP_ARRAY_WRITE) ||
               (op == sfs_pkg::OP_SECTOR_ERASE) || (op == sfs_pkg::OP_FULL_WIPE);
  endfunction : op_known

  function automatic logic op_array(input logic [7:0] op);
    op_array = (op == sfs_pkg::OP_ARRAY_READ) || (op == sfs_pkg::OP_ARRAY_WRITE);
  endfunction : op_array

  // ***************************************************************
  // state and shifter
  // ***************************************************************
  sfs_state_t    state_r;
  logic [CW-1:0] cnt_r;
  logic [15:0]   shift_r;
  logic [7:0]    op_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic [DW-1:0] tx_r;
  logic          wr_pend_r;
  logic          last_done_r;
  logic [15:0]   shift_nxt;
  logic [DW-1:0] rd_data;
  logic          busy;
  logic [7:0]    status;
  logic          wen_r;
  logic [1:0]    prot_r;
  logic          start_r;
  logic [1:0]    job_r;
  logic          addr_ok;

  assign shift_nxt = {shift_r[14:0], si_s};
  assign addr_ok   = (prot_r == 2'h0) ||
                     (prot_r == 2'h1 && addr_r[AW-1 -: 2] != 2'h3) ||
                     (prot_r == 2'h2 && addr_r[AW-1] == 1'b0);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r   <= SFS_IDLE;
      cnt_r     <= '0;
      shift_r   <= 16'h0000;
      op_r      <= 8'h00;
      addr_r    <= '0;
      wdata_r   <= '0;
      wr_pend_r <= 1'b0;
    end else if (sel_fall) begin
      state_r   <= SFS_OPCODE;
      cnt_r     <= '0;
      wr_pend_r <= 1'b0;
    end else if (!active) begin
      state_r <= SFS_IDLE;
    end else if (sck_rise) begin
      shift_r <= shift_nxt;
      cnt_r   <= cnt_r + CW'(1);
      case (state_r)
        SFS_OPCODE: begin
          if (cnt_r == CW'(sfs_pkg::OPCODE_BITS - 1)) begin
            op_r  <= shift_nxt[7:0];
            cnt_r <= '0;
            if (!op_known(shift_nxt[7:0])) state_r <= SFS_WAIT;
            else if (op_array(shift_nxt[7:0]) && busy) state_r <= SFS_WAIT;
            else if (shift_nxt[7:0] == sfs_pkg::OP_STATUS_READ)
              state_r <= READ_ONLY ? SFS_WAIT : SFS_STAT_OUT;
            else if (shift_nxt[7:0] == sfs_pkg::OP_STATUS_WRITE)
              state_r <= READ_ONLY ? SFS_WAIT : SFS_STAT_IN;
            else if (op_array(shift_nxt[7:0])) state_r <= SFS_ADDR;
            else if (shift_nxt[7:0] == sfs_pkg::OP_SECTOR_ERASE && EXTENDED)
              state_r <= SFS_ADDR;
            else begin
              state_r   <= SFS_WAIT;
              wr_pend_r <= !READ_ONLY && wen_r && prot_r == 2'h0 &&
                           (shift_nxt[7:0] == sfs_pkg::OP_SECTOR_ERASE ||
                            shift_nxt[7:0] == sfs_pkg::OP_FULL_WIPE);
            end
          end
        end
        SFS_ADDR: begin
          if (cnt_r == CW'(DW - 1)) begin
            addr_r <= shift_nxt[AW-1:0];
            cnt_r  <= '0;
            if (op_r == sfs_pkg::OP_ARRAY_READ) state_r <= SFS_DATA_OUT;
            else if (op_r == sfs_pkg::OP_ARRAY_WRITE) state_r <= SFS_DATA_IN;
            else begin
              state_r   <= SFS_WAIT;
              wr_pend_r <= !READ_ONLY && wen_r && prot_r == 2'h0;
            end
          end
        end
        SFS_DATA_IN: begin
          if (cnt_r == CW'(DW - 1)) begin
            wdata_r   <= shift_nxt[DW-1:0];
            state_r   <= SFS_WAIT;
            wr_pend_r <= !READ_ONLY && wen_r && addr_ok;
          end
        end
        SFS_DATA_OUT, SFS_STAT_OUT: begin
          if (cnt_r == CW'(DW - 1)) begin
            cnt_r <= '0;
            if (state_r == SFS_DATA_OUT) begin
              if (!EXTENDED && addr_r == '1) state_r <= SFS_WAIT;
              addr_r <= addr_r + AW'(1);
            end
          end
        end
        SFS_STAT_IN: begin
          if (cnt_r == CW'(7)) state_r <= SFS_WAIT;
        end
        default: begin
          cnt_r <= '0;
        end
      endcase
    end
  end

  // ***************************************************************
  // status register
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wen_r  <= sfs_pkg::STAT_RESET[sfs_pkg::STAT_WEN_POS];
      prot_r <= sfs_pkg::STAT_RESET[sfs_pkg::STAT_PROT_HI_POS -: 2];
    end else if (!READ_ONLY && sck_rise && state_r == SFS_OPCODE &&
                 cnt_r == CW'(sfs_pkg::OPCODE_BITS - 1)) begin
      if (shift_nxt[7:0] == sfs_pkg::OP_WRITE_ENABLE) wen_r <= 1'b1;
      else if (shift_nxt[7:0] == sfs_pkg::OP_WRITE_DISABLE) wen_r <= 1'b0;
    end else if (!READ_ONLY && sck_rise && state_r == SFS_STAT_IN && cnt_r == CW'(7) &&
                 wen_r) begin
      prot_r <= shift_nxt[sfs_pkg::STAT_PROT_HI_POS -: 2];
    end
  end

  assign status = READ_ONLY ? 8'h00 : {4'h0, prot_r, wen_r, busy};

  // ***************************************************************
  // launch of self-timed cycle after deselect
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      start_r <= 1'b0;
      job_r   <= 2'h0;
    end else begin
      start_r <= sel_rise && wr_pend_r && !busy;
      if (op_r == sfs_pkg::OP_ARRAY_WRITE) job_r <= sfs_pkg::SFS_JOB_WRITE;
      else if (op_r == sfs_pkg::OP_FULL_WIPE && EXTENDED) job_r <= sfs_pkg::SFS_JOB_FULL;
      else job_r <= sfs_pkg::SFS_JOB_SECTOR;
    end
  end

  sfs_flash_ctl #(
    .AW(AW), .DW(DW), .WRITE_CYCLES(WRITE_CYCLES),
    .SECTOR_CYCLES(SECTOR_CYCLES), .FULL_CYCLES(FULL_CYCLES)
  ) u_flash (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_rd_addr(addr_r),
    .o_rd_data(rd_data),
    .i_start  (start_r),
    .i_job    (job_r),
    .i_addr   ((op_r == sfs_pkg::OP_FULL_WIPE || !EXTENDED) ? AW'(0) : addr_r),
    .i_data   (wdata_r),
    .o_busy   (busy)
  );

  // ***************************************************************
  // serial output
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_so    <= 1'b0;
      o_so_oe <= 1'b0;
      tx_r    <= '0;
      last_done_r <= 1'b0;
    end else if (!active) begin
      o_so_oe <= 1'b0;
      last_done_r <= 1'b0;
    end else if (sck_fall && (state_r == SFS_DATA_OUT || state_r == SFS_STAT_OUT)) begin
      o_so_oe <= 1'b1;
      if (cnt_r == '0) begin
        o_so <= (state_r == SFS_STAT_OUT) ? status[7] : rd_data[DW-1];
        tx_r <= (state_r == SFS_STAT_OUT) ? DW'({status, 8'h00} >> (16 - DW)) << 1
                                          : rd_data << 1;
      end else begin
        o_so <= tx_r[DW-1];
        tx_r <= tx_r << 1;
      end
    end else if (sck_fall && state_r == SFS_WAIT && !EXTENDED && op_r == sfs_pkg::OP_ARRAY_READ) begin
      o_so_oe <= 1'b0;
      last_done_r <= 1'b1;
    end else if (sck_fall && state_r == SFS_WAIT) begin
      o_so_oe <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) o_oscillator_run <= 1'b0;
    else o_oscillator_run <= 1'b1;
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_so_released_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    sel_n_s |=> !o_so_oe) else $error("serial output driven while deselected");
  a_osc_always_on: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $past(i_arst_n) |-> o_oscillator_run) else $error("oscillator enable dropped");
  a_start_after_desel: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    start_r |-> $past(sel_rise)) else $error("cycle started while selected");
  a_busy_bit_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    status[sfs_pkg::STAT_BUSY_POS] == (busy && !READ_ONLY)) else $error("busy bit wrong");
  a_bad_opcode_wait: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_r == SFS_OPCODE && sck_rise && cnt_r == CW'(7) && !op_known(shift_nxt[7:0]))
    |=> state_r == SFS_WAIT) else $error("unknown opcode not ignored");
  a_wen_set_cmd: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!READ_ONLY && state_r == SFS_OPCODE && sck_rise && cnt_r == CW'(7) &&
     shift_nxt[7:0] == sfs_pkg::OP_WRITE_ENABLE) |=> wen_r) else $error("latch not set");
  a_wen_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ($fell(wen_r)) |-> $past(op_known(shift_nxt[7:0]) && shift_nxt[7:0] ==
     sfs_pkg::OP_WRITE_DISABLE)) else $error("latch cleared by other");
  a_busy_block_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (busy && state_r == SFS_OPCODE && sck_rise && cnt_r == CW'(7) &&
     op_array(shift_nxt[7:0])) |=> state_r == SFS_WAIT) else $error("array op taken while busy");
  a_status_top_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    status[7:4] == 4'h0) else $error("unused status bits set");
endmodule : sfs_spi_slave

// >>> inc/sfs_pkg.sv
// package: constants and types for the serial flash slave interface
package sfs_pkg;

  // ***************************************************************
  // instruction opcodes
  // ***************************************************************
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ    = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE   = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OP_FULL_WIPE     = 8'h60;

  // ***************************************************************
  // status register layout
  // ***************************************************************
  localparam int         STAT_BUSY_POS    = 0;
  localparam int         STAT_WEN_POS     = 1;
  localparam int         STAT_PROT_LO_POS = 2;
  localparam int         STAT_PROT_HI_POS = 3;
  localparam logic [7:0] STAT_RESET       = 8'h00;

  // ***************************************************************
  // field sizes and timing
  // ***************************************************************
  localparam int         OPCODE_BITS      = 8;
  localparam int         EXT_DISCARD_BITS = 7;
  localparam int         CLK_HZ           = 25_000_000;
  localparam int         WRITE_TIME_US    = 110;
  localparam int         SECTOR_TIME_MS   = 501;
  localparam int         FULL_TIME_MS     = 1002;
  localparam int         WRITE_CYCLES     = (WRITE_TIME_US * (CLK_HZ / 1_000_000));
  localparam int         SECTOR_CYCLES    = (SECTOR_TIME_MS * (CLK_HZ / 1000));
  localparam int         FULL_CYCLES      = (FULL_TIME_MS * (CLK_HZ / 1000));

  typedef enum logic [1:0] {
    SFS_JOB_WRITE,
    SFS_JOB_SECTOR,
    SFS_JOB_FULL
  } sfs_job_t;

endpackage : sfs_pkg

// >>> rtl/sfs_sync.sv
// module: two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module sfs_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_r;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : sfs_sync

// >>> rtl/sfs_flash_ctl.sv
// module: user flash array storage and self-timed write and erase engine
`timescale 1ns/1ns
module sfs_flash_ctl #(
  parameter int AW            = 9,
  parameter int DW            = 16,
  parameter int WRITE_CYCLES  = 2750,
  parameter int SECTOR_CYCLES = 12525000,
  parameter int FULL_CYCLES   = 25050000
) (
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  input  wire logic [AW-1:0] i_rd_addr,
  output logic      [DW-1:0] o_rd_data,
  input  wire logic          i_start,
  input  wire logic [1:0]    i_job,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_data,
  output logic               o_busy
);
  localparam int DEPTH = 1 << AW;
  logic [DW-1:0] mem [DEPTH];
  logic [31:0]   cnt_r;
  logic [1:0]    job_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] data_r;

  assign o_rd_data = mem[i_rd_addr];

  // ***************************************************************
  // cycle timer
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r  <= 32'h0000_0000;
      o_busy <= 1'b0;
      job_r  <= 2'h0;
      addr_r <= '0;
      data_r <= '0;
    end else if (i_start && !o_busy) begin
      o_busy <= 1'b1;
      job_r  <= i_job;
      addr_r <= i_addr;
      data_r <= i_data;
      if (i_job == sfs_pkg::SFS_JOB_WRITE) cnt_r <= 32'(WRITE_CYCLES);
      else if (i_job == sfs_pkg::SFS_JOB_SECTOR) cnt_r <= 32'(SECTOR_CYCLES);
      else cnt_r <= 32'(FULL_CYCLES);
    end else if (o_busy) begin
      if (cnt_r <= 32'h0000_0001) o_busy <= 1'b0;
      cnt_r <= cnt_r - 32'h0000_0001;
    end
  end

  // ***************************************************************
  // array update at end of cycle; write only clears bits
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    if (i_arst_n && o_busy && cnt_r <= 32'h0000_0001) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (job_r == sfs_pkg::SFS_JOB_WRITE && i == int'(addr_r))
          mem[i] <= mem[i] & data_r;
        else if (job_r == sfs_pkg::SFS_JOB_FULL)
          mem[i] <= '1;
        else if (job_r == sfs_pkg::SFS_JOB_SECTOR && (i >> (AW - 1)) == int'(addr_r[AW-1]))
          mem[i] <= '1;
      end
    end
  end
endmodule : sfs_flash_ctl

// >>> verif/sfs_master_model.sv
// file: serial bus master model that drives the flash slave interface
`timescale 1ns/1ns
module sfs_master_model (
  input  wire logic i_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output logic      o_select_n,
  output logic      o_sck,
  output logic      o_si
);
  logic so_last;
  logic oe_seen;
  initial begin
    o_select_n = 1'b1;
    o_sck      = 1'b0;
    o_si       = 1'b0;
    so_last    = 1'b0;
    oe_seen    = 1'b0;
  end
  // ***************************************************************
  // one framed exchange, n bits, msb first; shift clock idles low
  // ***************************************************************
  task automatic xfer(input logic [63:0] dout, input int n, output logic [63:0] din);
    din     = '0;
    oe_seen = 1'b0;
    @(posedge i_clk) o_select_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int k = n - 1; k >= 0; k--) begin
      @(posedge i_clk);
      o_sck <= 1'b0;
      o_si  <= dout[k];
      repeat (4) @(posedge i_clk);
      o_sck <= 1'b1;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      so_last = i_so_oe ? i_so : ~so_last;
      oe_seen = oe_seen | i_so_oe;
      din     = {din[62:0], so_last};
    end
    @(posedge i_clk) o_sck <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_select_n <= 1'b1;
    o_si       <= ~o_si;
    repeat (8) @(posedge i_clk);
  endtask : xfer
endmodule : sfs_master_model

// >>> verif/tb_sfs_spi_slave.sv
// file: self-checking testbench for the serial flash slave interface
`timescale 1ns/1ns
module tb_sfs_spi_slave;
  logic        clk;
  logic        arst_n;
  logic        select_n;
  logic        sck;
  logic        si;
  logic        so;
  logic        so_oe;
  logic        osc_run;
  logic [63:0] rx;
  logic [7:0]  st;
  int          failures;
  int          checks_done;

  sfs_spi_slave #(.EXTENDED(1'b1), .READ_ONLY(1'b0), .WRITE_CYCLES(300),
    .SECTOR_CYCLES(600), .FULL_CYCLES(800)) i_sfs_spi_slave (
    .i_clk            (clk),
    .i_arst_n         (arst_n),
    .i_select_n       (select_n),
    .i_sck            (sck),
    .i_si             (si),
    .o_so             (so),
    .o_so_oe          (so_oe),
    .o_oscillator_run (osc_run)
  );

  sfs_master_model i_sfs_master_model (
    .i_clk      (clk),
    .i_so       (so),
    .i_so_oe    (so_oe),
    .o_select_n (select_n),
    .o_sck      (sck),
    .o_si       (si)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ***************************************************************
  // shared helpers
  // ***************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic frame(input logic [63:0] dout, input int n);
    i_sfs_master_model.xfer(dout, n, rx);
  endtask : frame

  task automatic status_rd();
    frame({48'h0, 8'h05, 8'h00}, 16);
    st = rx[7:0];
  endtask : status_rd

  task automatic wait_idle();
    for (int k = 0; k < 40; k++) begin
      status_rd();
      if (st[0] === 1'b0) break;
    end
    check({15'h0, st[0]}, 16'h0000);
  endtask : wait_idle

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset();
    check({15'h0, osc_run}, 16'h0001);
    check({15'h0, so_oe}, 16'h0000);
    status_rd();
    check({8'h0, st}, 16'h0000);
  endtask : t_reset

  task automatic t_latch();
    frame({56'h0, 8'h06}, 8);
    status_rd();
    check({8'h0, st}, 16'h0002);
    frame({56'h0, 8'h04}, 8);
    status_rd();
    check({8'h0, st}, 16'h0000);
  endtask : t_latch

  task automatic t_unknown();
    frame({40'h0, 8'h07, 8'h06, 8'h05}, 24);
    check({15'h0, i_sfs_master_model.oe_seen}, 16'h0000);
    status_rd();
    check({8'h0, st}, 16'h0000);
  endtask : t_unknown

  task automatic t_status_wr();
    frame({56'h0, 8'h06}, 8);
    frame({48'h0, 8'h01, 8'h0C}, 16);
    status_rd();
    check({8'h0, st}, 16'h000E);
    frame({48'h0, 8'h01, 8'h00}, 16);
    status_rd();
    check({8'h0, st}, 16'h0002);
  endtask : t_status_wr

  task automatic t_erase();
    frame({40'h0, 8'h20, 16'h0000}, 24);
    status_rd();
    check({8'h0, st}, 16'h0003);
    frame({24'h0, 8'h03, 16'h0005, 16'h0}, 40);
    check({15'h0, i_sfs_master_model.oe_seen}, 16'h0000);
    wait_idle();
    status_rd();
    check({8'h0, st}, 16'h0002);
  endtask : t_erase

  task automatic t_array();
    frame({24'h0, 8'h02, 16'hFE05, 16'hA5C3}, 40);
    wait_idle();
    frame({8'h0, 8'h03, 16'h0005, 32'h0}, 56);
    check(rx[31:16], 16'hA5C3);
    check(rx[15:0], 16'hFFFF);
    frame({56'h0, 8'h04}, 8);
    frame({24'h0, 8'h02, 16'h0006, 16'h0000}, 40);
    frame({24'h0, 8'h03, 16'h0006, 16'h0}, 40);
    check(rx[15:0], 16'hFFFF);
  endtask : t_array

  task automatic t_wipe();
    frame({56'h0, 8'h06}, 8);
    frame({56'h0, 8'h60}, 8);
    status_rd();
    check({15'h0, st[0]}, 16'h0001);
    wait_idle();
    frame({24'h0, 8'h03, 16'h0005, 16'h0}, 40);
    check(rx[15:0], 16'hFFFF);
  endtask : t_wipe

  // ***************************************************************
  // verdict, watchdog and main sequence
  // ***************************************************************
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #4_000_000;
    failures++;
    print_verdict();
  end

  initial begin
    failures    = 0;
    checks_done = 0;
    arst_n      = 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_latch();
    t_unknown();
    t_status_wr();
    t_erase();
    t_array();
    t_wipe();
    print_verdict();
  end
endmodule : tb_sfs_spi_slave
